// ### design/arb_status_if.sv
// Grant and busy status from the arbiter core to the Port B sequencer, Port B activity back
`timescale 1ns/1ps
`default_nettype none
interface arb_status_if;
   logic grant_b;
   logic refresh_busy;
   logic precharge_busy;
   logic b_active;
   modport arbiter (output grant_b, output refresh_busy, output precharge_busy, input b_active);
   modport sequencer (input grant_b, input refresh_busy, input precharge_busy, output b_active);
endinterface
`default_nettype wire

// ### design/dram_arb_pkg.sv
// Constants and types for the dual-port DRAM access arbiter
// Operation
// R01: Refresh first, then the granted port, then the ungranted port.
// R02: Grant stays with last port after access until other port requests.
// R03: Requests must be synchronous to clk_sys; external synchronisers otherwise.
// R04: Port B access starts only from its request input.
// R05: Granted, no refresh, precharge done: RAS asserts with Port B request.
// R06: Port B holds request whole access; its negation ends RAS.
// R07: With column enable bit 0 set, CAS follows enables after RAS ends.
// R08: Ungranted B starts one or two edges after grant, per delay select.
// R09: Grant moves to B only when A idle, unlocked, and B requesting.
// R10: New A request before previous ends keeps grant at Port A.
// R11: Port B folds its chip select into its request.
// R12: Early acknowledge asserts with Port B RAS, holds until request negates.
// R13: Grant output high means Port B owns array, low means Port A.
// R14: Grant changes after current request negates, one or two clocks before RAS.
// R15: Grant holds until other port requests while granted port is idle.
// R16: Hold input keeps current owner; the other port waits.
// R17: Hold input never blocks refresh; it only freezes the grant.
// R18: A shut-out port gets wait states until it may access.
// R19: External buffers steer shared inputs by the grant output.
// R20: After reset Port A is granted, grant output low.
// R21: All decisions are taken on rising edges of clk_sys.
package dram_arb_pkg;
   localparam int CLK_PERIOD_NS  = 20;
   localparam int PRECHARGE_NS   = 60;
   localparam int PRECHARGE_CYC  = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PCH_W          = 3;
   localparam int CAS_W          = 4;
   localparam logic GRANT_RESET  = 1'b0;
   // Longest Port B wait with no lock, refresh or Port A demand in the way
   localparam int B_WAIT_MAX     = 8;

   typedef enum logic [3:0] {
      B_IDLE  = 4'b0001,
      B_DELAY = 4'b0010,
      B_RAS   = 4'b0100,
      B_DONE  = 4'b1000
   } port_b_state_t;
endpackage

// ### design/dual_port_dram_access_arbiter.sv
// Arbiter among refresh, Port A and Port B for one shared DRAM array
`timescale 1ns/1ps
`default_nettype none
module dual_port_dram_access_arbiter
   import dram_arb_pkg::*;
#(
   parameter int PRE_CYC = PRECHARGE_CYC
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   // Port A
   input  wire logic             port_a_access_request,
   input  wire logic             port_a_address_strobe,
   // Port B
   input  wire logic             port_b_access_request,
   // Shared controls
   input  wire logic             hold_grant,
   input  wire logic             refresh_request,
   input  wire logic             column_enable_bit0,
   input  wire logic [CAS_W-1:0] column_strobe_enables,
   input  wire logic             grant_start_delay_select,
   // Outputs
   output logic                  port_b_owns_array,
   output logic                  port_b_early_ack,
   output logic                  port_b_ras,
   output logic [CAS_W-1:0]      port_b_cas,
   output logic                  port_a_wait,
   output logic                  port_b_wait,
   output logic                  refresh_active
);
   arb_status_if st ();

   logic             a_req;
   logic             a_req_q;
   logic             a_relock;
   logic             next_ras_b;
   logic             next_ack_b;
   logic [PCH_W-1:0] pch_cnt;

   assign a_req = port_a_access_request || port_a_address_strobe;

   // Refresh runs only while no port access holds RAS, then outranks both [R01] [R17]
   always_ff @(posedge clk_sys) begin
      if (!rst_b)
         refresh_active <= 1'b0;
      else if (refresh_request && !port_b_ras && !(a_req && !port_b_owns_array))
         refresh_active <= 1'b1;
      else if (!refresh_request)
         refresh_active <= 1'b0;
   end

   // Precharge count after Port B RAS or refresh ends
   always_ff @(posedge clk_sys) begin
      if (!rst_b)
         pch_cnt <= '0;
      else if ((port_b_ras && !next_ras_b) || (refresh_active && !refresh_request))
         pch_cnt <= PCH_W'(PRE_CYC);
      else if (pch_cnt != '0)
         pch_cnt <= pch_cnt - PCH_W'(1);
   end

   assign st.refresh_busy   = refresh_active || refresh_request;
   assign st.precharge_busy = (pch_cnt != '0);
   assign st.grant_b        = port_b_owns_array;

   // A strobe arriving while the prior A request still stands keeps A owner
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         a_req_q  <= 1'b0;
         a_relock <= 1'b0;
      end else begin
         a_req_q  <= port_a_access_request;
         a_relock <= port_a_address_strobe && a_req_q; // [R10]
      end
   end

   // Grant: sticky owner, moves only when owner idle and other requests [R02] [R15] [R21]
   always_ff @(posedge clk_sys) begin
      if (!rst_b)
         port_b_owns_array <= GRANT_RESET; // [R20]
      else if (!hold_grant) begin // [R16]
         if (!port_b_owns_array && !a_req && !a_relock && port_b_access_request)
            port_b_owns_array <= 1'b1; // [R09] [R14]
         else if (port_b_owns_array && a_req && !st.b_active && !port_b_ras && !port_b_access_request)
            port_b_owns_array <= 1'b0; // [R13] [R14]
      end
   end

   port_b_sequencer u_seq (
      .clk_sys                  (clk_sys),
      .rst_b                    (rst_b),
      .port_b_access_request    (port_b_access_request),
      .grant_start_delay_select (grant_start_delay_select),
      .st                       (st),
      .next_ras_b               (next_ras_b),
      .next_ack_b               (next_ack_b)
   );

   // Registered RAS and early acknowledge [R05] [R06] [R12]
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         port_b_ras       <= 1'b0;
         port_b_early_ack <= 1'b0;
      end else begin
         port_b_ras       <= next_ras_b;
         port_b_early_ack <= next_ack_b;
      end
   end

   // CAS may outlive RAS while enables stay on and bit0 is still set [R07]
   always_ff @(posedge clk_sys) begin
      if (!rst_b)
         port_b_cas <= '0;
      else if (next_ras_b)
         port_b_cas <= column_strobe_enables;
      else if (column_enable_bit0)
         port_b_cas <= port_b_cas & column_strobe_enables;
      else
         port_b_cas <= '0;
   end

   // Wait states for a port shut out of the array [R18] [R16]
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         port_a_wait <= 1'b0;
         port_b_wait <= 1'b0;
      end else begin
         port_a_wait <= a_req && (port_b_owns_array || refresh_active);
         port_b_wait <= port_b_access_request && !next_ack_b;
      end
   end

   // Checks
   sequence s_b_req_rise;
      !port_b_access_request ##1 port_b_access_request;
   endsequence

   AST_RESET_GRANT: assert property (@(posedge clk_sys) !rst_b |=> !port_b_owns_array) // [R20]
      else $error("grant not at Port A after reset");
   AST_ACK_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
      port_b_early_ack && port_b_access_request |=> port_b_early_ack || $fell(port_b_access_request)
      || !port_b_access_request) // [R12]
      else $error("early ack dropped during request");
   AST_RAS_END: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !port_b_access_request |=> !port_b_ras) // [R06]
      else $error("RAS stayed after request negated");
   AST_ACK_WITH_RAS: assert property (@(posedge clk_sys) disable iff (!rst_b)
      port_b_ras == port_b_early_ack) // [R12]
      else $error("ack and RAS differ");
   AST_HOLD_FREEZE: assert property (@(posedge clk_sys) disable iff (!rst_b)
      hold_grant |=> $stable(port_b_owns_array)) // [R16]
      else $error("grant moved under hold");
   AST_TO_B: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(port_b_owns_array) |-> $past(port_b_access_request) && !$past(a_req)) // [R09]
      else $error("grant moved to B illegally");
   AST_RAS_NEEDS_GRANT: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(port_b_ras) |-> $past(port_b_owns_array)) // [R14]
      else $error("RAS before grant");
   AST_B_START: assert property (@(posedge clk_sys) disable iff (!rst_b)
      s_b_req_rise ##0 (port_b_owns_array && !st.refresh_busy && !st.precharge_busy
      && st.b_active == 1'b0 && !grant_start_delay_select) |=> ##[0:1] port_b_ras) // [R05]
      else $error("Port B RAS late");
   AST_REFRESH_NO_RAS: assert property (@(posedge clk_sys) disable iff (!rst_b)
      refresh_active && !$past(port_b_ras) |-> !$rose(port_b_ras)) // [R17]
      else $error("Port B RAS during refresh");

   // Grant has just moved to Port B
   sequence s_grant_b_taken;
      !port_b_owns_array ##1 port_b_owns_array;
   endsequence

   // Clean start: still requesting, nothing in the way
   sequence s_b_clear;
      port_b_access_request && !st.refresh_busy && !st.precharge_busy;
   endsequence

   // Run length of Port B wait states that nothing legal explains
   logic [3:0] b_wait_run;

   always_ff @(posedge clk_sys) begin
      if (!rst_b)
         b_wait_run <= '0;
      else if (!port_b_wait || hold_grant || st.refresh_busy || a_req || a_relock)
         b_wait_run <= '0;
      else if (b_wait_run != 4'hF)
         b_wait_run <= b_wait_run + 4'h1;
   end

   // RAS, acknowledge, refresh and CAS outputs leave reset low
   AST_RESET_OUTPUTS: assert property (@(posedge clk_sys) // [R20]
      !rst_b |=> !port_b_ras && !port_b_early_ack && !refresh_active && port_b_cas == '0)
      else $error("output not cleared by reset");

   // Acknowledge starts exactly with RAS
   AST_ACK_RISE: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R12]
      $rose(port_b_early_ack) |-> $rose(port_b_ras))
      else $error("early ack rose without RAS");

   // Acknowledge only ends once the request is gone
   AST_ACK_FALL: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R12]
      $fell(port_b_early_ack) |-> !$past(port_b_access_request))
      else $error("early ack fell while request stood");

   // Grant leaves B only when B is idle and not asking
   AST_TO_A_B_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R15]
      $fell(port_b_owns_array) |-> !$past(port_b_access_request) && !$past(port_b_ras))
      else $error("grant left Port B mid access");

   // Grant leaves B only for a Port A request
   AST_TO_A_ON_REQ: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R02]
      $fell(port_b_owns_array) |-> $past(a_req))
      else $error("grant left Port B unasked");

   // A back-to-back Port A strobe keeps the array with A
   AST_RELOCK_KEEPS_A: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R10]
      $rose(port_b_owns_array) |-> !$past(a_relock))
      else $error("grant moved to B during A relock");

   // Lock keeps A as owner
   AST_HOLD_KEEPS_A: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R16]
      hold_grant && !port_b_owns_array |=> !port_b_owns_array)
      else $error("lock let B take the array");

   // Lock keeps B as owner
   AST_HOLD_KEEPS_B: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R16]
      hold_grant && port_b_owns_array |=> port_b_owns_array)
      else $error("lock let A take the array");

   // Lock must not delay a refresh that is free to start
   AST_REFRESH_UNDER_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R17]
      hold_grant && refresh_request && !port_b_ras && !(a_req && !port_b_owns_array)
      |=> refresh_active)
      else $error("lock blocked refresh");

   // Refresh owns the array outright
   AST_RAS_OFF_IN_REFRESH: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R01]
      refresh_active |-> !port_b_ras)
      else $error("Port B RAS while refresh active");

   // Port A shut out while B owns the array
   AST_A_WAIT: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R18]
      a_req && port_b_owns_array |=> port_a_wait)
      else $error("Port A not stalled while B owns");

   // Port B shut out while A owns the array
   AST_B_WAIT: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R18]
      port_b_access_request && !port_b_owns_array |=> port_b_wait)
      else $error("Port B not stalled while A owns");

   // Wait and acknowledge never overlap
   AST_B_WAIT_ACK_EXCL: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R18]
      !(port_b_wait && port_b_early_ack))
      else $error("Port B wait and ack together");

   // Wait states end within a bound once nothing legal holds B back
   AST_B_WAIT_BOUND: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R18]
      b_wait_run < 4'(B_WAIT_MAX))
      else $error("Port B stalled too long");

   // Without the extend option CAS ends with RAS
   AST_CAS_NO_EXT: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R07]
      !column_enable_bit0 && !next_ras_b |=> port_b_cas == '0)
      else $error("CAS outlived RAS without extend");

   // During RAS, CAS follows the enables
   AST_CAS_WITH_RAS: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R07]
      next_ras_b |=> port_b_cas == $past(column_strobe_enables))
      else $error("CAS does not follow enables");

   // Precharge is counted as soon as RAS ends
   AST_PCH_AFTER_RAS: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R05]
      $fell(port_b_ras) |-> st.precharge_busy)
      else $error("no precharge after RAS");

   // No new RAS while precharge is counting
   AST_NO_RAS_IN_PCH: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R05]
      st.precharge_busy |-> !next_ras_b)
      else $error("RAS during precharge");

   // Undelayed start: RAS one edge after the grant is seen
   AST_START_NO_DELAY: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R08]
      s_grant_b_taken ##0 (s_b_clear and !grant_start_delay_select) |=> port_b_ras)
      else $error("undelayed Port B start late");

   // Delayed start: no RAS on the first edge after the grant
   AST_DELAY_NOT_EARLY: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R08]
      s_grant_b_taken ##0 grant_start_delay_select |=> !port_b_ras)
      else $error("delayed Port B start early");

   // Delayed start: RAS on the second edge after the grant
   AST_START_DELAY: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R08]
      s_grant_b_taken ##0 (s_b_clear and grant_start_delay_select) ##1 s_b_clear |=> port_b_ras)
      else $error("delayed Port B start late");
endmodule
`default_nettype wire

// ### design/port_b_sequencer.sv
// Port B access sequencer: RAS start, early acknowledge and Port B activity status
`timescale 1ns/1ps
`default_nettype none
module port_b_sequencer
   import dram_arb_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // Port B request and start delay
   input  wire logic        port_b_access_request,
   input  wire logic        grant_start_delay_select,
   // Status from the arbiter
   arb_status_if.sequencer  st,
   // Results
   output logic             next_ras_b,
   output logic             next_ack_b
);
   port_b_state_t state;
   logic          just_granted;

   assign st.b_active = (state == B_RAS) || (state == B_DELAY);

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state        <= B_IDLE;
         just_granted <= 1'b0;
      end else begin
         just_granted <= 1'b0;
         unique case (state)
            B_IDLE: begin
               // Only the request input starts an access [R04]
               if (port_b_access_request && st.grant_b && !st.refresh_busy && !st.precharge_busy) begin
                  if (grant_start_delay_select && just_granted)
                     state <= B_DELAY; // [R08]
                  else
                     state <= B_RAS; // [R05]
               end
            end
            B_DELAY: begin
               // A refresh or precharge arriving in the delay cycle must still win
               if (!port_b_access_request)
                  state <= B_IDLE;
               else if (!st.refresh_busy && !st.precharge_busy)
                  state <= B_RAS; // [R01] [R08]
            end
            B_RAS: begin
               if (!port_b_access_request)
                  state <= B_IDLE; // [R06]
            end
            B_DONE: begin
               state <= B_IDLE;
            end
         endcase
         if (!st.grant_b)
            just_granted <= 1'b1;
      end
   end

   // RAS and acknowledge decoded so the top can register them [R12]
   always_comb begin
      next_ras_b = 1'b0;
      next_ack_b = 1'b0;
      if (port_b_access_request) begin
         if (state == B_RAS) begin
            next_ras_b = 1'b1;
            next_ack_b = 1'b1;
         end else if (state == B_IDLE && st.grant_b && !st.refresh_busy && !st.precharge_busy
                      && !(grant_start_delay_select && just_granted)) begin
            next_ras_b = 1'b1;
            next_ack_b = 1'b1;
         end else if (state == B_DELAY && !st.refresh_busy && !st.precharge_busy) begin
            next_ras_b = 1'b1;
            next_ack_b = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ### dv/cpu_pair_model.sv
// Two processors sharing the DRAM array: request side of Port A and Port B
`timescale 1ns/1ps
`default_nettype none
module cpu_pair_model (
   // Clock
   input  wire logic clk_sys,
   // Bench commands
   input  wire logic want_a,
   input  wire logic want_b,
   // Arbiter feedback
   input  wire logic b_ack,
   // Requests
   output logic      req_a,
   output logic      req_b
);
   logic [1:0] ack_cnt;
   logic       done;
   // Commands change at the falling edge, so requests are clock synchronous
   assign req_a = want_a;
   // Chip select is already folded into want_b
   assign req_b = want_b & ~done;
   // Request stays up until two acknowledged cycles have passed
   always_ff @(negedge clk_sys) begin
      if (!want_b) begin
         ack_cnt <= 2'h0;
         done    <= 1'h0;
      end else if (b_ack && ack_cnt == 2'h1) begin
         done <= 1'h1;
      end else if (b_ack) begin
         ack_cnt <= ack_cnt + 2'h1;
      end
   end
endmodule
`default_nettype wire

// ### dv/dual_port_dram_access_arbiter_tb_top.sv
// Self-checking bench for the dual-port DRAM access arbiter
`timescale 1ns/1ps
`default_nettype none
module dual_port_dram_access_arbiter_tb_top;
   import dram_arb_pkg::*;
   logic             clk_sys = 1'h0;
   logic             rst_b = 1'h0;
   logic             want_a = 1'h0;
   logic             want_b = 1'h0;
   logic             stb_a = 1'h0;
   logic             hold = 1'h0;
   logic             refr = 1'h0;
   logic             ext = 1'h0;
   logic             dsel = 1'h0;
   logic [CAS_W-1:0] cen = 4'h0;
   logic             req_a, req_b, grant, ack, ras, a_wait, b_wait, refr_act;
   logic [CAS_W-1:0] cas;
   int               miscompares = 0;
   int               checks = 0;
   int               n;

   always #10 clk_sys = ~clk_sys;

   cpu_pair_model u_cpu_pair_model (.clk_sys, .want_a, .want_b, .b_ack(ack), .req_a, .req_b);
   dual_port_dram_access_arbiter u_dual_port_dram_access_arbiter (
      .clk_sys, .rst_b, .port_a_access_request(req_a), .port_a_address_strobe(stb_a),
      .port_b_access_request(req_b), .hold_grant(hold), .refresh_request(refr),
      .column_enable_bit0(ext), .column_strobe_enables(cen), .grant_start_delay_select(dsel),
      .port_b_owns_array(grant), .port_b_early_ack(ack), .port_b_ras(ras), .port_b_cas(cas),
      .port_a_wait(a_wait), .port_b_wait(b_wait), .refresh_active(refr_act));

   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk_v(input string what, input logic [3:0] exp, input logic [3:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_n(input string what, input int exp, input int got);
      checks++;
      if (got != exp) begin
         miscompares++;
         $display("unexpected %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   // Bounded wait at falling edges; c counts the edges passed
   task automatic wait_for(ref logic s, input logic v, output int c);
      c = 0;
      while (s !== v && c < 60) begin
         @(negedge clk_sys);
         c++;
      end
      if (s !== v) begin
         miscompares++;
         $display("unexpected wait timeout expected %b seen %b", v, s);
         wrap_up();
      end
   endtask

   // Finishes one Port B access and checks its end; precharge is let pass after
   task automatic b_finish();
      @(negedge clk_sys);
      chk_v("ack while request held", 4'h1, {3'h0, ack});
      wait_for(req_b, 1'h0, n);
      chk_v("ras after release", 4'h0, {3'h0, ras});
      chk_v("ack after release", 4'h0, {3'h0, ack});
      want_b = 1'h0;
      repeat (6) @(negedge clk_sys);
   endtask

   task automatic t_switch(input logic d);
      dsel = d;
      want_b = 1'h1;
      wait_for(grant, 1'h1, n);
      wait_for(ras, 1'h1, n);
      chk_n("grant to ras edges", d ? 2 : 1, n);
      chk_v("ack with ras", 4'h1, {3'h0, ack});
      b_finish();
      chk_v("grant kept", 4'h1, {3'h0, grant});
      $display("test switch done");
   endtask

   task automatic t_granted();
      want_b = 1'h1;
      wait_for(ras, 1'h1, n);
      chk_n("granted request to ras", 1, n);
      b_finish();
      $display("test granted done");
   endtask

   task automatic t_cas();
      ext = 1'h1;
      cen = 4'hF;
      want_b = 1'h1;
      wait_for(ras, 1'h1, n);
      wait_for(ras, 1'h0, n);
      chk_v("cas beyond ras", 4'hF, cas);
      cen = 4'h0;
      want_b = 1'h0;
      ext = 1'h0;
      repeat (6) @(negedge clk_sys);
      $display("test cas done");
   endtask

   task automatic t_refresh();
      hold = 1'h1;
      refr = 1'h1;
      @(negedge clk_sys);
      want_b = 1'h1;
      repeat (3) @(negedge clk_sys);
      chk_v("refresh under hold", 4'h1, {3'h0, refr_act});
      chk_v("ras during refresh", 4'h0, {3'h0, ras});
      chk_v("b wait in refresh", 4'h1, {3'h0, b_wait});
      refr = 1'h0;
      hold = 1'h0;
      wait_for(ras, 1'h1, n);
      b_finish();
      $display("test refresh done");
   endtask

   task automatic t_hold();
      hold = 1'h1;
      want_a = 1'h1;
      repeat (8) @(negedge clk_sys);
      chk_v("grant under hold", 4'h1, {3'h0, grant});
      chk_v("a wait under hold", 4'h1, {3'h0, a_wait});
      hold = 1'h0;
      wait_for(grant, 1'h0, n);
      want_a = 1'h0;
      repeat (4) @(negedge clk_sys);
      $display("test hold done");
   endtask

   task automatic t_contend();
      want_a = 1'h1;
      stb_a = 1'h1;
      want_b = 1'h1;
      repeat (6) @(negedge clk_sys);
      chk_v("grant with a busy", 4'h0, {3'h0, grant});
      chk_v("b shut out", 4'h1, {3'h0, b_wait});
      stb_a = 1'h0;
      want_a = 1'h0;
      wait_for(grant, 1'h1, n);
      wait_for(ras, 1'h1, n);
      b_finish();
      $display("test contend done");
   endtask

   initial begin
      repeat (16) @(negedge clk_sys);
      rst_b = 1'h1;
      @(negedge clk_sys);
      chk_v("grant after reset", 4'h0, {3'h0, grant});
      chk_v("ras after reset", 4'h0, {3'h0, ras});
      t_switch(1'h0);
      t_granted();
      t_cas();
      t_refresh();
      t_hold();
      t_switch(1'h1);
      want_a = 1'h1;
      wait_for(grant, 1'h0, n);
      want_a = 1'h0;
      repeat (4) @(negedge clk_sys);
      t_contend();
      wrap_up();
   end
endmodule
`default_nettype wire
